// ===== scr_board_model.sv
// Board and host model: strap resistors, sleep clock, reference clock, power-down drive.
`timescale 1ns/1ps

module scr_board_model
(
   input  wire logic       mclk,      // Bench clock, paces pin traffic.
   input  wire logic       sample,    // Strap pins in input mode.
   input  wire logic [3:0] tie_lo,    // Resistor to ground: freq, auto, cfg0, cfg1.
   input  wire logic       sleep_on,  // Sleep oscillator fitted.
   input  wire logic       ref_38,    // 1 = 38.4 MHz reference, 0 = 26 MHz.
   input  wire logic       pd_req_n,  // Host power-down request, low = down.
   output logic [3:0]      straps,    // Strap pin levels.
   output logic            sleep_pin, // Sleep clock pin.
   output logic            ref_pin,   // Reference clock pin.
   output logic            pd_pin_n   // Power-down pin.
);
   logic churn_reg = 1'b0;

   // Released strap pins carry their normal traffic, so they toggle every cycle.
   always_ff @(posedge mclk)
      churn_reg <= ~churn_reg;
   assign straps   = sample ? ~tie_lo : {4{churn_reg}};
   assign pd_pin_n = pd_req_n;

   // The reference runs from time zero, well before power-down is released.
   initial
   begin
      ref_pin   = 1'b0;
      forever
         #(ref_38 ? 13.02 : 19.23) ref_pin = ~ref_pin;
   end

   // An unfitted sleep pin floats to its pull-up level.
   initial
   begin
      sleep_pin = 1'b1;
      forever
      begin
         if (sleep_on)
            #15259 sleep_pin = ~sleep_pin;
         else
            #100 sleep_pin = 1'b1;
      end
   end
endmodule

// ===== scr_params.svh
// Constants of the strap capture and reference clock select block.
`ifndef SCR_PARAMS_SVH
`define SCR_PARAMS_SVH
`define SCR_MCLK_KHZ    125000
`define SCR_REF_LO_KHZ  26000
`define SCR_REF_HI_KHZ  38400
`define SCR_SLP_HZ      32768
`define SCR_REF_THRESH  ((`SCR_REF_LO_KHZ + `SCR_REF_HI_KHZ) * 500 / `SCR_SLP_HZ)
`define SCR_SLP_TMO     (2 * `SCR_MCLK_KHZ * 1000 / `SCR_SLP_HZ)
`define SCR_REG_STATUS  8'h00
`define SCR_REG_CTRL    8'h04
`define SCR_REG_REFCNT  8'h08
`define SCR_ST_CFG_LO   0
`define SCR_ST_FREQ     2
`define SCR_ST_AUTO     3
`define SCR_ST_SEL38    4
`define SCR_ST_SLPOK    5
`define SCR_ST_RUN      6
`define SCR_CT_OSC      0
`define SCR_CT_GPIO     1
`define SCR_CT_RESET    2'h3
`define SCR_IN_PD       0
`define SCR_IN_FREQ     1
`define SCR_IN_AUTO     2
`define SCR_IN_CFG0     3
`define SCR_IN_CFG1     4
`define SCR_IN_SLP      5
`define SCR_IN_REF      6
// Idle pin levels: straps and sleep pin high through pull-ups, power-down and reference low.
`define SCR_SYNC_IDLE   7'h3e
`endif

// ===== scr_pkg.sv
// Types shared by the strap capture and reference clock select block.
package scr_pkg;
   typedef enum logic [1:0] {
      SCR_PDOWN   = 2'b00,
      SCR_CAPTURE = 2'b01,
      SCR_DETECT  = 2'b10,
      SCR_RUN     = 2'b11
   } scr_state_e;
endpackage

// ===== scr_strap_refclk.sv
// Strap capture, reference clock frequency select and oscillator enable.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "scr_params.svh"

module scr_strap_refclk
   import scr_pkg::*;
#(
   parameter int SLP_TMO_CYC = `SCR_SLP_TMO
)
(
   input  wire logic        mclk,                 // System clock, 125 MHz.
   input  wire logic        reset,                // Asynchronous reset, active high.
   input  wire logic        full_powerdown_in_n,  // Power-down pin, low = power down.
   input  wire logic        refclk_freq_strap,    // Frequency select strap pin.
   input  wire logic        refclk_autodetect_strap, // Autodetect strap pin.
   input  wire logic        cfg_bit0,             // Host configuration strap 0.
   input  wire logic        cfg_bit1,             // Host configuration strap 1.
   input  wire logic        sleep_clock_in,       // Optional sleep clock pin.
   input  wire logic        refclk_in,            // Reference clock pin.
   input  wire logic [7:0]  reg_addr,             // Register byte address.
   input  wire logic [31:0] reg_wdata,            // Register write data.
   input  wire logic        reg_wr,               // Write strobe.
   input  wire logic        reg_rd,               // Read strobe.
   output logic      [31:0] reg_rdata,            // Read data, one cycle after strobe.
   output logic             ext_osc_enable_out,   // Oscillator enable, active high.
   output logic             gpio0_out,            // GPIO 0 level when not oscillator enable.
   output logic             strap_sample_out,     // Strap pins in input mode with pull-up.
   output logic             powerdown_out,        // Block held in full power-down.
   output logic             refclk_sel38_out,     // 1 = 38.4 MHz, 0 = 26 MHz.
   output logic             sleep_tick_out        // One pulse per sleep clock period while running with the sleep clock verified.
);

   // ***********************************************
   // Input synchronisers
   // ***********************************************
   logic [6:0] pin_raw;
   logic [6:0] sync1_reg;
   logic [6:0] sync2_reg;

   assign pin_raw = {refclk_in, sleep_clock_in, cfg_bit1, cfg_bit0,
                     refclk_autodetect_strap, refclk_freq_strap, full_powerdown_in_n};

   // Straps and the sleep pin idle high through their pull-ups. Resetting the
   // synchroniser to those levels keeps a false sleep edge from following reset.
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         sync1_reg <= `SCR_SYNC_IDLE;
         sync2_reg <= `SCR_SYNC_IDLE;
      end
      else
      begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
      end
   end

   function automatic logic rise(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction

   // ***********************************************
   // Sequencing, capture and detection
   // ***********************************************
   scr_state_e  state_reg, state_next;
   logic        slp_prev_reg, slp_prev_next;
   logic        ref_prev_reg, ref_prev_next;
   logic        armed_reg, armed_next;
   logic [13:0] tmo_reg, tmo_next;
   logic [11:0] refcnt_reg, refcnt_next;
   logic        freq_reg, freq_next;
   logic        auto_reg, auto_next;
   logic [1:0]  cfg_reg, cfg_next;
   logic        sel38_reg, sel38_next;
   logic        slpok_reg, slpok_next;
   logic [1:0]  ctrl_reg, ctrl_next;
   logic [31:0] rdata_next;
   logic        osc_next, gpio_next, sample_next, pdown_next, tick_next;
   logic        pd_s, slp_rise, ref_rise;

   assign pd_s     = sync2_reg[`SCR_IN_PD];
   assign slp_rise = rise(sync2_reg[`SCR_IN_SLP], slp_prev_reg);
   assign ref_rise = rise(sync2_reg[`SCR_IN_REF], ref_prev_reg);

   always_comb
   begin
      state_next    = state_reg;
      slp_prev_next = sync2_reg[`SCR_IN_SLP];
      ref_prev_next = sync2_reg[`SCR_IN_REF];
      armed_next    = armed_reg;
      tmo_next      = tmo_reg;
      refcnt_next   = refcnt_reg;
      freq_next     = freq_reg;
      auto_next     = auto_reg;
      cfg_next      = cfg_reg;
      sel38_next    = sel38_reg;
      slpok_next    = slpok_reg;
      ctrl_next     = ctrl_reg;
      rdata_next    = 32'h0000_0000;
      unique case (state_reg)
         SCR_PDOWN:
         begin
            // Leaving power-down is the full reset that recaptures the straps.
            if (pd_s)
               state_next = SCR_CAPTURE;
         end
         SCR_CAPTURE:
         begin
            // Pins are still inputs with pull-up, so an open strap reads 1.
            // Capture is the only state that loads the strap copies, so later
            // traffic on the released pins cannot disturb them.
            freq_next  = sync2_reg[`SCR_IN_FREQ];
            auto_next  = sync2_reg[`SCR_IN_AUTO];
            cfg_next   = {sync2_reg[`SCR_IN_CFG1], sync2_reg[`SCR_IN_CFG0]};
            sel38_next = ~sync2_reg[`SCR_IN_FREQ];
            slpok_next = 1'b0;
            armed_next = 1'b0;
            tmo_next   = 14'h0000;
            refcnt_next = 12'h000;
            ctrl_next  = `SCR_CT_RESET;
            state_next = sync2_reg[`SCR_IN_AUTO] ? SCR_DETECT : SCR_RUN;
         end
         SCR_DETECT:
         begin
            // Reference edges are counted over one sleep clock period.
            tmo_next = tmo_reg + 14'h0001;
            if (armed_reg && ref_rise && refcnt_reg != 12'hFFF)
               refcnt_next = refcnt_reg + 12'h001;
            if (slp_rise && !armed_reg)
            begin
               armed_next = 1'b1;
               tmo_next   = 14'h0000;
            end
            else if (slp_rise)
            begin
               slpok_next = 1'b1;
               sel38_next = (refcnt_reg > 12'(`SCR_REF_THRESH));
               state_next = SCR_RUN;
            end
            else if (tmo_reg >= 14'(SLP_TMO_CYC))
               // A missing sleep clock falls back to the frequency strap.
               state_next = SCR_RUN;
         end
         SCR_RUN:
         begin
            if (slp_rise)
               tmo_next = 14'h0000;
            else if (tmo_reg < 14'(SLP_TMO_CYC))
               tmo_next = tmo_reg + 14'h0001;
            else
               slpok_next = 1'b0;
            if (slp_rise && auto_reg)
               slpok_next = 1'b1;
         end
      endcase
      // Software may only retune the oscillator enable once the block is running.
      if (reg_wr && reg_addr == `SCR_REG_CTRL && state_reg == SCR_RUN)
         ctrl_next = reg_wdata[1:0];
      if (reg_rd)
      begin
         unique case (reg_addr)
            `SCR_REG_STATUS:
            begin
               rdata_next[`SCR_ST_CFG_LO +: 2] = cfg_reg;
               rdata_next[`SCR_ST_FREQ]  = freq_reg;
               rdata_next[`SCR_ST_AUTO]  = auto_reg;
               rdata_next[`SCR_ST_SEL38] = sel38_reg;
               rdata_next[`SCR_ST_SLPOK] = slpok_reg;
               rdata_next[`SCR_ST_RUN]   = (state_reg == SCR_RUN);
            end
            `SCR_REG_CTRL:   rdata_next[1:0] = ctrl_reg;
            `SCR_REG_REFCNT: rdata_next[11:0] = refcnt_reg;
            default:         rdata_next = 32'h0000_0000;
         endcase
      end
      // A low power-down pin overrides every state.
      if (!pd_s)
         state_next = SCR_PDOWN;
      sample_next = (state_next == SCR_PDOWN) || (state_next == SCR_CAPTURE);
      pdown_next  = (state_next == SCR_PDOWN);
      osc_next    = (state_next == SCR_RUN) && slpok_next && ctrl_next[`SCR_CT_OSC];
      gpio_next   = ctrl_next[`SCR_CT_GPIO];
      tick_next   = (state_reg == SCR_RUN) && slpok_reg && slp_rise;
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         state_reg          <= SCR_PDOWN;
         slp_prev_reg       <= 1'b1;
         ref_prev_reg       <= 1'b0;
         armed_reg          <= 1'b0;
         tmo_reg            <= 14'h0000;
         refcnt_reg         <= 12'h000;
         freq_reg           <= 1'b1;
         auto_reg           <= 1'b1;
         cfg_reg            <= 2'h3;
         sel38_reg          <= 1'b0;
         slpok_reg          <= 1'b0;
         ctrl_reg           <= `SCR_CT_RESET;
         reg_rdata          <= 32'h0000_0000;
         ext_osc_enable_out <= 1'b0;
         gpio0_out          <= 1'b1;
         strap_sample_out   <= 1'b1;
         powerdown_out      <= 1'b1;
         refclk_sel38_out   <= 1'b0;
         sleep_tick_out     <= 1'b0;
      end
      else
      begin
         state_reg          <= state_next;
         slp_prev_reg       <= slp_prev_next;
         ref_prev_reg       <= ref_prev_next;
         armed_reg          <= armed_next;
         tmo_reg            <= tmo_next;
         refcnt_reg         <= refcnt_next;
         freq_reg           <= freq_next;
         auto_reg           <= auto_next;
         cfg_reg            <= cfg_next;
         sel38_reg          <= sel38_next;
         slpok_reg          <= slpok_next;
         ctrl_reg           <= ctrl_next;
         reg_rdata          <= rdata_next;
         ext_osc_enable_out <= osc_next;
         gpio0_out          <= gpio_next;
         strap_sample_out   <= sample_next;
         powerdown_out      <= pdown_next;
         refclk_sel38_out   <= sel38_next;
         sleep_tick_out     <= tick_next;
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   pd_forces_down_a: assert property (@(posedge mclk) disable iff (reset)
      !pd_s |=> powerdown_out && state_reg == SCR_PDOWN)
      else $error("power-down pin low did not force power-down");

   pd_rise_capture_a: assert property (@(posedge mclk) disable iff (reset)
      state_reg == SCR_PDOWN && pd_s |=> state_reg == SCR_CAPTURE)
      else $error("power-down release did not start a capture");

   strap_capture_a: assert property (@(posedge mclk) disable iff (reset)
      state_reg == SCR_CAPTURE && pd_s
         |=> cfg_reg == $past(sync2_reg[`SCR_IN_CFG1 -: 2]) && freq_reg == $past(sync2_reg[`SCR_IN_FREQ]))
      else $error("straps not captured from the pins");

   pins_released_a: assert property (@(posedge mclk) disable iff (reset)
      state_reg == SCR_RUN && pd_s |=> !strap_sample_out)
      else $error("strap pins not released after capture");

   pullup_window_a: assert property (@(posedge mclk) disable iff (reset)
      state_reg == SCR_CAPTURE |-> strap_sample_out)
      else $error("pull-up not active while sampling");

   straps_held_a: assert property (@(posedge mclk) disable iff (reset)
      (state_reg != SCR_CAPTURE)[*2] |-> $stable(cfg_reg) && $stable(freq_reg) && $stable(auto_reg))
      else $error("captured straps changed outside capture");

   manual_select_a: assert property (@(posedge mclk) disable iff (reset)
      state_reg == SCR_CAPTURE && pd_s && !sync2_reg[`SCR_IN_AUTO]
         |=> state_reg == SCR_RUN ##0 refclk_sel38_out == !freq_reg)
      else $error("manual frequency select wrong");

   osc_gated_a: assert property (@(posedge mclk) disable iff (reset)
      ext_osc_enable_out |-> slpok_reg && state_reg == SCR_RUN)
      else $error("oscillator enabled without sleep clock");

   osc_drive_a: assert property (@(posedge mclk) disable iff (reset)
      state_reg == SCR_RUN && pd_s && slpok_next && ctrl_next[`SCR_CT_OSC] |=> ext_osc_enable_out)
      else $error("oscillator enable not driven");

   cfg_readback_a: assert property (@(posedge mclk) disable iff (reset)
      reg_rd && reg_addr == `SCR_REG_STATUS |=> reg_rdata[1:0] == $past(cfg_reg))
      else $error("host configuration bits not readable");

   ctrl_write_gate_a: assert property (@(posedge mclk) disable iff (reset)
      reg_wr && reg_addr == `SCR_REG_CTRL && (state_reg == SCR_PDOWN || state_reg == SCR_DETECT)
         |=> $stable(ctrl_reg))
      else $error("control changed by a write outside run");

endmodule

// ===== tb.sv
// Self-checking bench for strap capture and reference clock selection.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
   begin \
      checked++; \
      if ((got) !== (exp)) \
      begin \
         err_total++; \
         $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
      end \
   end

module tb;
   typedef struct packed
   {
      logic [3:0] tie;
      logic       slp;
      logic       r38;
      logic       sel;
      logic       osc;
      logic [6:0] st;
   } scr_row_s;

   logic        mclk, reset, reg_wr, reg_rd, sleep_on, ref_38, pd_req_n, sample, pd_n, slp, ref_clk;
   logic [3:0]  tie_lo, straps;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, d;
   logic        osc, gpio0, pdown, sel38, tick;
   int          err_total, checked, n, ticks;
   scr_row_s    rows [7] = '{
      '{4'h2, 1'b0, 1'b0, 1'b0, 1'b0, 7'h47}, '{4'h3, 1'b0, 1'b0, 1'b1, 1'b0, 7'h53},
      '{4'h6, 1'b0, 1'b0, 1'b0, 1'b0, 7'h46}, '{4'hf, 1'b0, 1'b1, 1'b1, 1'b0, 7'h50},
      '{4'h1, 1'b0, 1'b0, 1'b1, 1'b0, 7'h5b}, '{4'h1, 1'b1, 1'b0, 1'b0, 1'b1, 7'h6b},
      '{4'h0, 1'b1, 1'b1, 1'b1, 1'b1, 7'h7f}};

   scr_board_model board
   (
      .mclk(mclk), .sample(sample), .tie_lo(tie_lo), .sleep_on(sleep_on), .ref_38(ref_38),
      .pd_req_n(pd_req_n), .straps(straps), .sleep_pin(slp), .ref_pin(ref_clk), .pd_pin_n(pd_n)
   );

   scr_strap_refclk dut
   (
      .mclk(mclk), .reset(reset), .full_powerdown_in_n(pd_n), .refclk_freq_strap(straps[0]),
      .refclk_autodetect_strap(straps[1]), .cfg_bit0(straps[2]), .cfg_bit1(straps[3]),
      .sleep_clock_in(slp), .refclk_in(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_osc_enable_out(osc),
      .gpio0_out(gpio0), .strap_sample_out(sample), .powerdown_out(pdown),
      .refclk_sel38_out(sel38), .sleep_tick_out(tick)
   );

   // ****************************************
   // Bus and sequencing tasks
   // ****************************************
   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge mclk);
      reg_wr <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask

   task automatic chk_idle();
      `CHK("powerdown", 1'b1, pdown)
      `CHK("sample", 1'b1, sample)
      `CHK("osc", 1'b0, osc)
      `CHK("gpio0", 1'b1, gpio0)
   endtask

   initial
   begin
      mclk = 1'b0;
      forever
         #4 mclk = ~mclk;
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      {reg_wr, reg_rd, sleep_on, ref_38, pd_req_n, tie_lo, reg_addr, reg_wdata} = '0;
      {err_total, checked} = '0;
      reset = 1'b1;
      repeat (16) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      #1 chk_idle();
      `CHK("sel38_rst", 1'b0, sel38)
      foreach (rows[i])
      begin
         pd_req_n <= 1'b0;
         repeat (4) @(posedge mclk);
         #1 chk_idle();
         tie_lo   <= rows[i].tie;
         sleep_on <= rows[i].slp;
         ref_38   <= rows[i].r38;
         @(posedge mclk);
         pd_req_n <= 1'b1;
         d = 32'h0000_0000;
         // Power-down drops at capture, but autodetect runs up to two sleep periods more.
         for (n = 0; n < 10000 && d[6] !== 1'b1; n++)
            rd(8'h00);
         if (n == 10000)
         begin
            err_total++;
            stop_test();
         end
         repeat (2) @(posedge mclk);
         #1;
         `CHK("pdown_off", 1'b0, pdown)
         `CHK("sel38", rows[i].sel, sel38)
         `CHK("osc_en", rows[i].osc, osc)
         `CHK("sample_off", 1'b0, sample)
         rd(8'h00);
         `CHK("status", rows[i].st, d[6:0])
         repeat (50) @(posedge mclk);
         rd(8'h00);
         `CHK("status_held", {25'h0, rows[i].st}, d)
      end
      rd(8'h04);
      `CHK("ctrl_rst", 32'h0000_0003, d)
      @(posedge mclk);
      #1 `CHK("rdata_one", 32'h0000_0000, reg_rdata)
      wr(8'h04, 32'h0000_0002);
      `CHK("osc_off", 1'b0, osc)
      wr(8'h04, 32'h0000_0001);
      `CHK("osc_on", 1'b1, osc)
      `CHK("gpio0_lo", 1'b0, gpio0)
      wr(8'h00, 32'h0000_0000);
      rd(8'h00);
      `CHK("status_ro", 32'h0000_007f, d)
      rd(8'h0c);
      `CHK("unmapped", 32'h0000_0000, d)
      rd(8'h08);
      `CHK("refcnt_hi", 1'b1, d[11:0] > 12'd982)
      ticks = 0;
      repeat (10000)
      begin
         @(posedge mclk);
         #1;
         if (tick === 1'b1)
            ticks++;
      end
      `CHK("ticks", 1'b1, ticks >= 2 && ticks <= 3)
      pd_req_n <= 1'b0;
      repeat (4) @(posedge mclk);
      #1 `CHK("pd_abort", 1'b1, pdown)
      `CHK("pd_osc", 1'b0, osc)
      reset <= 1'b1;
      @(posedge mclk);
      #1 chk_idle();
      stop_test();
   end
endmodule
